// [src/drc_pkg.sv]
package drc_pkg;

    // Register indices as printed (word addresses on the control port)
    localparam logic [15:0] DRC_ADDR_FX_STATUS    = 16'h0e01;
    localparam logic [15:0] DRC_ADDR_A_SLOPE_REL  = 16'h0e82;
    localparam logic [15:0] DRC_ADDR_A_KNEE       = 16'h0e83;
    localparam logic [15:0] DRC_ADDR_A_GATE_KNEE  = 16'h0e84;
    localparam logic [15:0] DRC_ADDR_B_DETECT     = 16'h0e89;
    localparam logic [15:0] DRC_ADDR_B_TIMING     = 16'h0e8a;

    // Reset values
    localparam logic [15:0] DRC_RST_A_SLOPE_REL   = 16'h0018;
    localparam logic [15:0] DRC_RST_A_KNEE        = 16'h0000;
    localparam logic [15:0] DRC_RST_A_GATE_KNEE   = 16'h0000;
    localparam logic [15:0] DRC_RST_B_DETECT      = 16'h0018;
    localparam logic [15:0] DRC_RST_B_TIMING      = 16'h0930;

    // Writable bit masks (unlisted bits read zero)
    localparam logic [15:0] DRC_MSK_A_SLOPE_REL   = 16'h00ff;
    localparam logic [15:0] DRC_MSK_A_KNEE        = 16'h07ff;
    localparam logic [15:0] DRC_MSK_A_GATE_KNEE   = 16'h03ff;
    localparam logic [15:0] DRC_MSK_B_DETECT      = 16'hfff8;
    localparam logic [15:0] DRC_MSK_B_TIMING      = 16'h1ffc;

    // Field positions
    localparam int DRC_POS_QR_DCY   = 6;
    localparam int DRC_POS_HI_COMP  = 3;
    localparam int DRC_POS_LO_COMP  = 0;
    localparam int DRC_POS_KNEE_IP  = 5;
    localparam int DRC_POS_KNEE_OP  = 0;
    localparam int DRC_POS_RMS      = 11;
    localparam int DRC_POS_PK       = 9;
    localparam int DRC_POS_NG       = 8;
    localparam int DRC_POS_MODE     = 7;
    localparam int DRC_POS_DET      = 6;
    localparam int DRC_POS_K2OP     = 5;
    localparam int DRC_POS_QR       = 4;
    localparam int DRC_POS_AC       = 3;
    localparam int DRC_POS_ATK      = 9;
    localparam int DRC_POS_DCY      = 5;
    localparam int DRC_POS_MINGAIN  = 2;
    localparam int DRC_POS_STS      = 4;

    // Highest legal codes of each field, and the lowest legal attack code
    localparam logic [1:0] DRC_MAX_QR_DCY  = 2'h2;
    localparam logic [2:0] DRC_MAX_HI_COMP = 3'h5;
    localparam logic [2:0] DRC_MAX_LO_COMP = 3'h4;
    localparam logic [5:0] DRC_MAX_KNEE_IP = 6'h3c;
    localparam logic [4:0] DRC_MAX_KNEE_OP = 5'h1e;
    localparam logic [3:0] DRC_MIN_ATK     = 4'h1;
    localparam logic [3:0] DRC_MAX_ATK     = 4'hb;
    localparam logic [3:0] DRC_MAX_DCY     = 4'hb;
    localparam logic [2:0] DRC_MAX_MINGAIN = 3'h4;

    // Status bit of each controller channel inside the 12-bit field
    localparam int DRC_STS_A_L = 4;
    localparam int DRC_STS_B_R = 7;

    // Control-port request and answer
    typedef struct packed {
        logic        wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } drc_req_t;

    typedef struct packed {
        logic [15:0] rdata;
        logic        hit;
    } drc_rsp_t;

    // One stereo sample pair passing through the buffer
    typedef struct packed {
        logic [23:0] left;
        logic [23:0] right;
    } drc_smp_t;

    typedef enum logic [1:0] {
        DRC_BUF_EMPTY = 2'b01,
        DRC_BUF_FULL  = 2'b10
    } drc_buf_st_t;

endpackage

// [src/drc_top.sv]
`timescale 1ns/10ps
// Operation
// - Fast-release rate code 0..2 selects 0.725, 1.45, 5.8 ms; 3 reserved.
// - Upper slope codes 0..5 valid, 6..7 reserved, resets to 3.
// - Lower slope codes 0..4 valid, above reserved, resets to 0.
// - Knee input level six bits, -0.75dB steps, top legal code 0x3c.
// - Knee output level five bits, -0.75dB steps, code 0x1f reserved.
// - Gate knee input applies only while the noise gate is enabled.
// - Gate knee output applies only while its enable bit is set.
// - Read-only status bits 15:4 show filter, controller, equalizer enables.
// - Enable refused when clock budget short; active paths kept; error raised.
// - RMS threshold five bits, -30dB down to -76.5dB, in RMS mode.
// - Crest threshold two bits, 12 to 30dB, used in peak mode.
// - Detect kind bit 7: 0 peak, 1 RMS; resets to peak.
// - Detect enable bit 6 turns detection on; resets off.
// - Gate enable bit 8; fast release bit 4, clip guard bit 3 reset on.
// - Attack rate 1..11 legal, 181us doubling to 185.6ms.
// - Decay rate 0..11 legal, 1.45ms to 2.97s, resets to 9.
// - Gain floor codes 0..4 legal, above reserved.
module drc_top
    import drc_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // Control port
    input  wire drc_req_t    req,
    input  wire logic        req_valid,
    output drc_rsp_t         rsp,
    output logic             rsp_valid,
    // Path enable requests and clock budget from the mixer side
    input  wire logic [11:0] path_enable_req,
    input  wire logic [11:0] path_fits_clock,
    output logic             underclock_err,
    // Applied settings
    output logic [15:0]      drc_a_cfg,
    output logic [15:0]      drc_b_cfg,
    output logic [9:0]       gate_a_applied,
    output logic [9:0]       rms_or_crest_thr,
    // Sample stream in and out
    input  wire drc_smp_t    in_smp,
    input  wire logic        in_valid,
    output logic             in_ready,
    output drc_smp_t         out_smp,
    output logic             out_valid,
    input  wire logic        out_ready
);

    logic [15:0] a_slope_r, a_knee_r, a_gate_r, b_det_r, b_tim_r;
    logic [11:0] sts_r;
    logic        wr_hit;

    // Register writes, masked to implemented bits
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            a_slope_r <= DRC_RST_A_SLOPE_REL;
            a_knee_r  <= DRC_RST_A_KNEE;
            a_gate_r  <= DRC_RST_A_GATE_KNEE;
            b_det_r   <= DRC_RST_B_DETECT;
            b_tim_r   <= DRC_RST_B_TIMING;
        end else if (req_valid && req.wr) begin
            unique case (req.addr)
                DRC_ADDR_A_SLOPE_REL: a_slope_r <= req.wdata & DRC_MSK_A_SLOPE_REL;
                DRC_ADDR_A_KNEE:      a_knee_r  <= req.wdata & DRC_MSK_A_KNEE;
                DRC_ADDR_A_GATE_KNEE: a_gate_r  <= req.wdata & DRC_MSK_A_GATE_KNEE;
                DRC_ADDR_B_DETECT:    b_det_r   <= req.wdata & DRC_MSK_B_DETECT;
                DRC_ADDR_B_TIMING:    b_tim_r   <= req.wdata & DRC_MSK_B_TIMING;
                default: ;                                        // Status is read-only
            endcase
        end
    end

    assign wr_hit = (req.addr == DRC_ADDR_A_SLOPE_REL) || (req.addr == DRC_ADDR_A_KNEE)
                 || (req.addr == DRC_ADDR_A_GATE_KNEE) || (req.addr == DRC_ADDR_B_DETECT)
                 || (req.addr == DRC_ADDR_B_TIMING) || (req.addr == DRC_ADDR_FX_STATUS);

    // Read answer one cycle after request; unmapped reads zero with hit low
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rsp       <= '0;
            rsp_valid <= 1'b0;
        end else begin
            rsp_valid <= req_valid;
            rsp.hit   <= req_valid && wr_hit;
            if (req_valid) begin
                unique case (req.addr)
                    DRC_ADDR_FX_STATUS:   rsp.rdata <= {sts_r, 4'h0};
                    DRC_ADDR_A_SLOPE_REL: rsp.rdata <= a_slope_r;
                    DRC_ADDR_A_KNEE:      rsp.rdata <= a_knee_r;
                    DRC_ADDR_A_GATE_KNEE: rsp.rdata <= a_gate_r;
                    DRC_ADDR_B_DETECT:    rsp.rdata <= b_det_r;
                    DRC_ADDR_B_TIMING:    rsp.rdata <= b_tim_r;
                    default:              rsp.rdata <= 16'h0000;
                endcase
            end
        end
    end

    // Path enables: a new path only starts if the clock budget allows it;
    // running paths are kept so a short budget never drops live audio
    logic [11:0] sts_nxt;
    logic [11:0] refused;
    always_comb begin
        refused = path_enable_req & ~sts_r & ~path_fits_clock;
        sts_nxt = path_enable_req & (sts_r | path_fits_clock);
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sts_r          <= 12'h000;
            underclock_err <= 1'b0;
        end else begin
            sts_r          <= sts_nxt;
            underclock_err <= |refused;
        end
    end

    // Applied gate knee: fields gated by their enables.
    // Reserved codes are passed through untouched, since software keeps clear of them
    logic ng_a_on;
    logic k2op_a_on;
    assign ng_a_on   = b_det_r[DRC_POS_NG];
    assign k2op_a_on = b_det_r[DRC_POS_K2OP];
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            gate_a_applied <= 10'h000;
        end else begin
            gate_a_applied[9:5] <= ng_a_on   ? a_gate_r[9:5] : 5'h00;
            gate_a_applied[4:0] <= k2op_a_on ? a_gate_r[4:0] : 5'h00;
        end
    end

    // Detection threshold: RMS level or crest factor by detect kind
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rms_or_crest_thr <= 10'h000;
        end else if (!b_det_r[DRC_POS_DET]) begin
            rms_or_crest_thr <= 10'h000;
        end else if (b_det_r[DRC_POS_MODE]) begin
            rms_or_crest_thr <= {5'h10, b_det_r[DRC_POS_RMS +: 5]};
        end else begin
            rms_or_crest_thr <= {8'h00, b_det_r[DRC_POS_PK +: 2]};
        end
    end

    // Settings bundles for the gain engine
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            drc_a_cfg <= 16'h0000;
            drc_b_cfg <= 16'h0000;
        end else begin
            drc_a_cfg <= {a_knee_r[10:0], a_slope_r[7:3]};
            drc_b_cfg <= {b_tim_r[12:2], b_det_r[4:3], a_slope_r[2:0]};
        end
    end

    // Two-entry sample buffer; in_ready drops only when both slots hold data
    drc_smp_t    slot0_r, slot1_r;
    drc_buf_st_t buf_r;
    logic        cnt2_r;
    logic        push, pop;
    assign push = in_valid && in_ready;
    assign pop  = out_valid && out_ready;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            buf_r     <= DRC_BUF_EMPTY;
            cnt2_r    <= 1'b0;
            out_valid <= 1'b0;
            in_ready  <= 1'b1;
            slot0_r   <= '0;
            slot1_r   <= '0;
        end else begin
            unique case ({push, pop})
                2'b10: begin
                    if (!out_valid) begin
                        slot0_r   <= in_smp;
                        out_valid <= 1'b1;
                    end else begin
                        slot1_r  <= in_smp;
                        cnt2_r   <= 1'b1;
                        in_ready <= 1'b0;
                        buf_r    <= DRC_BUF_FULL;
                    end
                end
                2'b01: begin
                    if (cnt2_r) begin
                        slot0_r  <= slot1_r;
                        cnt2_r   <= 1'b0;
                        in_ready <= 1'b1;
                        buf_r    <= DRC_BUF_EMPTY;
                    end else begin
                        out_valid <= 1'b0;
                    end
                end
                2'b11: slot0_r <= in_smp;   // Only possible with one slot held
                default: ;
            endcase
        end
    end
    assign out_smp = slot0_r;

    // Assertions
    sequence s_refuse;
        path_enable_req[DRC_STS_A_L] && !sts_r[DRC_STS_A_L] && !path_fits_clock[DRC_STS_A_L];
    endsequence

    property p_refuse_err;
        @(posedge sys_clk) disable iff (rst) s_refuse |=> underclock_err && !sts_r[DRC_STS_A_L];
    endproperty
    a_refuse_err: assert property (p_refuse_err) else $error("refused enable not flagged");

    property p_keep_active;
        @(posedge sys_clk) disable iff (rst)
            sts_r[DRC_STS_B_R] && path_enable_req[DRC_STS_B_R] |=> sts_r[DRC_STS_B_R];
    endproperty
    a_keep_active: assert property (p_keep_active) else $error("active path dropped");

    property p_status_read;
        @(posedge sys_clk) disable iff (rst)
            req_valid && !req.wr && req.addr == DRC_ADDR_FX_STATUS
            |=> rsp_valid && rsp.rdata == {$past(sts_r), 4'h0};
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read wrong");

    property p_gate_in;
        @(posedge sys_clk) disable iff (rst) !ng_a_on |=> gate_a_applied[9:5] == 5'h00;
    endproperty
    a_gate_in: assert property (p_gate_in) else $error("gate knee in leaked");

    property p_gate_out;
        @(posedge sys_clk) disable iff (rst)
            k2op_a_on |=> gate_a_applied[4:0] == $past(a_gate_r[4:0]);
    endproperty
    a_gate_out: assert property (p_gate_out) else $error("gate knee out not applied");

    property p_rms_mode;
        @(posedge sys_clk) disable iff (rst)
            b_det_r[DRC_POS_DET] && b_det_r[DRC_POS_MODE]
            |=> rms_or_crest_thr[4:0] == $past(b_det_r[15:11]);
    endproperty
    a_rms_mode: assert property (p_rms_mode)
        else $error("rms threshold not selected");

    property p_det_off;
        @(posedge sys_clk) disable iff (rst) !b_det_r[DRC_POS_DET] |=> rms_or_crest_thr == 10'h000;
    endproperty
    a_det_off: assert property (p_det_off) else $error("detect off but threshold live");

    property p_no_overflow;
        @(posedge sys_clk) disable iff (rst) !in_ready |-> cnt2_r && out_valid;
    endproperty
    a_no_overflow: assert property (p_no_overflow) else $error("buffer stall without data");

    property p_ro_status;
        @(posedge sys_clk) disable iff (rst)
            req_valid && req.wr && req.addr == DRC_ADDR_FX_STATUS
            |=> $stable(a_slope_r) && $stable(a_knee_r) && $stable(a_gate_r)
                && $stable(b_det_r) && $stable(b_tim_r);
    endproperty
    a_ro_status: assert property (p_ro_status)
        else $error("status write changed a register");

    // Budget: a path appears only if it ran already or the clock allows it
    property p_new_needs_budget;
        @(posedge sys_clk) disable iff (rst)
            1'b1 |=> (sts_r & ~$past(sts_r) & ~$past(path_fits_clock)) == 12'h000;
    endproperty
    a_new_needs_budget: assert property (p_new_needs_budget)
        else $error("path started without clock budget");

    // No error without a refused request; the flag must not stick
    property p_err_cause;
        @(posedge sys_clk) disable iff (rst) refused == 12'h000 |=> !underclock_err;
    endproperty
    a_err_cause: assert property (p_err_cause)
        else $error("underclock error without refusal");

    // Register write reaches the gain-engine bundles two edges later
    sequence s_wr_knee;
        req_valid && req.wr && req.addr == DRC_ADDR_A_KNEE;
    endsequence

    sequence s_wr_slope;
        req_valid && req.wr && req.addr == DRC_ADDR_A_SLOPE_REL;
    endsequence

    sequence s_wr_timing;
        req_valid && req.wr && req.addr == DRC_ADDR_B_TIMING;
    endsequence

    sequence s_wr_detect;
        req_valid && req.wr && req.addr == DRC_ADDR_B_DETECT;
    endsequence

    property p_knee_cfg;
        @(posedge sys_clk) disable iff (rst)
            s_wr_knee |-> ##2 drc_a_cfg[15:5] == $past(req.wdata[10:0], 2);
    endproperty
    a_knee_cfg: assert property (p_knee_cfg)
        else $error("knee levels not applied");

    property p_slope_cfg;
        @(posedge sys_clk) disable iff (rst)
            s_wr_slope |-> ##2 (drc_a_cfg[4:0] == $past(req.wdata[7:3], 2)
                && drc_b_cfg[2:0] == $past(req.wdata[2:0], 2));
    endproperty
    a_slope_cfg: assert property (p_slope_cfg)
        else $error("slope or release rate not applied");

    property p_timing_cfg;
        @(posedge sys_clk) disable iff (rst)
            s_wr_timing |-> ##2 drc_b_cfg[15:5] == $past(req.wdata[12:2], 2);
    endproperty
    a_timing_cfg: assert property (p_timing_cfg)
        else $error("attack, decay or gain floor not applied");

    property p_enables_cfg;
        @(posedge sys_clk) disable iff (rst)
            s_wr_detect |-> ##2 drc_b_cfg[4:3] == $past(req.wdata[4:3], 2);
    endproperty
    a_enables_cfg: assert property (p_enables_cfg)
        else $error("fast release or clip guard not applied");

    // Peak mode shows the crest code in the low bits only
    property p_peak_mode;
        @(posedge sys_clk) disable iff (rst)
            b_det_r[DRC_POS_DET] && !b_det_r[DRC_POS_MODE]
            |=> rms_or_crest_thr == {8'h00, $past(b_det_r[DRC_POS_PK +: 2])};
    endproperty
    a_peak_mode: assert property (p_peak_mode)
        else $error("crest threshold not selected");

    // Unmapped places answer zero with hit low
    property p_unmapped;
        @(posedge sys_clk) disable iff (rst)
            req_valid && !wr_hit |=> rsp_valid && !rsp.hit && rsp.rdata == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped place answered");

    // Stream: first word shows next cycle; state code tracks the fill
    sequence s_first_push;
        in_valid && in_ready && !out_valid;
    endsequence

    property p_first_push;
        @(posedge sys_clk) disable iff (rst)
            s_first_push |=> out_valid && out_smp == $past(in_smp);
    endproperty
    a_first_push: assert property (p_first_push)
        else $error("first sample not presented");

    property p_buf_state;
        @(posedge sys_clk) disable iff (rst)
            (buf_r == DRC_BUF_FULL) == (cnt2_r && !in_ready);
    endproperty
    a_buf_state: assert property (p_buf_state)
        else $error("buffer state disagrees with fill");

endmodule // drc_top

// [dv/drc_mixer_model.sv]
`timescale 1ns/10ps
// Mixer-side stand-in: pushes numbered sample pairs, sinks them with stalls
module drc_mixer_model
    import drc_pkg::*;
(
    // Clock
    sys_clk,
    // Control from the bench
    src_on,
    stall,
    // Stream to and from the block
    in_smp,
    in_valid,
    in_ready,
    out_smp,
    out_valid,
    out_ready,
    // Counts seen by the bench
    tx_n,
    rx_n,
    rx_bad
);
    input  wire logic     sys_clk;
    input  wire logic     src_on;
    input  wire logic     stall;
    output drc_smp_t      in_smp;
    output logic          in_valid;
    input  wire logic     in_ready;
    input  wire drc_smp_t out_smp;
    input  wire logic     out_valid;
    output logic          out_ready;
    output int            tx_n;
    output int            rx_n;
    output int            rx_bad;

    logic took;

    // Idle at time zero
    initial begin
        in_valid = 1'b0;
        in_smp = '0;
        out_ready = 1'b0;
        tx_n = 0;
        rx_n = 0;
        rx_bad = 0;
    end

    // Offer held until taken; a released bus shows inverted data, not stale
    always @(posedge sys_clk) begin
        took = in_valid && in_ready;
        if (took) tx_n = tx_n + 1;
        if (out_valid && out_ready) begin
            if (out_smp !== {24'(rx_n), ~24'(rx_n)}) rx_bad = rx_bad + 1;
            rx_n = rx_n + 1;
        end
        #1;
        if (!in_valid || took) in_valid = src_on && ($urandom_range(3) != 0);
        in_smp = in_valid ? {24'(tx_n), ~24'(tx_n)} : ~in_smp;
        out_ready = !stall && ($urandom_range(2) != 0);
    end
endmodule // drc_mixer_model

// [dv/tb.sv]
`timescale 1ns/10ps
module tb
    import drc_pkg::*;
;
    // Clock, reset and control port
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    drc_req_t    req = '0;
    logic        req_valid = 1'b0;
    drc_rsp_t    rsp;
    logic        rsp_valid;
    // Path enables and settings
    logic [11:0] pen = 12'h000;
    logic [11:0] fits = 12'hfff;
    logic        uerr;
    logic [15:0] a_cfg, b_cfg;
    logic [9:0]  gate_ap, thr;
    // Stream
    drc_smp_t    in_smp, out_smp;
    logic        in_valid, in_ready, out_valid, out_ready;
    logic        src_on = 1'b0;
    logic        stall = 1'b0;
    int          tx_n, rx_n, rx_bad;
    int          fails = 0;
    int          num_checks = 0;
    // Expected register contents, starting at their reset values
    logic [15:0] regs [logic [15:0]] = '{DRC_ADDR_A_SLOPE_REL: 16'h0018,
        DRC_ADDR_A_KNEE: 16'h0000, DRC_ADDR_A_GATE_KNEE: 16'h0000,
        DRC_ADDR_B_DETECT: 16'h0018, DRC_ADDR_B_TIMING: 16'h0930};
    logic [15:0] mk [logic [15:0]] = '{DRC_ADDR_A_SLOPE_REL: DRC_MSK_A_SLOPE_REL,
        DRC_ADDR_A_KNEE: DRC_MSK_A_KNEE, DRC_ADDR_A_GATE_KNEE: DRC_MSK_A_GATE_KNEE,
        DRC_ADDR_B_DETECT: DRC_MSK_B_DETECT, DRC_ADDR_B_TIMING: DRC_MSK_B_TIMING};
    logic [15:0] adr [5] = '{DRC_ADDR_A_SLOPE_REL, DRC_ADDR_A_KNEE,
        DRC_ADDR_A_GATE_KNEE, DRC_ADDR_B_DETECT, DRC_ADDR_B_TIMING};

    drc_top DUT (.sys_clk(sys_clk), .rst(rst), .req(req), .req_valid(req_valid),
        .rsp(rsp), .rsp_valid(rsp_valid), .path_enable_req(pen),
        .path_fits_clock(fits), .underclock_err(uerr), .drc_a_cfg(a_cfg),
        .drc_b_cfg(b_cfg), .gate_a_applied(gate_ap), .rms_or_crest_thr(thr),
        .in_smp(in_smp), .in_valid(in_valid), .in_ready(in_ready), .out_smp(out_smp),
        .out_valid(out_valid), .out_ready(out_ready));

    drc_mixer_model u_mix (.sys_clk(sys_clk), .src_on(src_on), .stall(stall),
        .in_smp(in_smp), .in_valid(in_valid), .in_ready(in_ready), .out_smp(out_smp),
        .out_valid(out_valid), .out_ready(out_ready), .tx_n(tx_n), .rx_n(rx_n),
        .rx_bad(rx_bad));

    // 250 MHz
    always #2 sys_clk = ~sys_clk;

    task check(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task summarize;
        $display("checks=%0d mismatches=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // One access; answer sampled the cycle after the request is taken
    task acc(input logic wr, input logic [15:0] a, input logic [15:0] wd,
             output logic [15:0] rd, output logic hit);
        @(posedge sys_clk) #1;
        req = '{wr, a, wd};
        req_valid = 1'b1;
        @(posedge sys_clk) #1;
        req_valid = 1'b0;
        check(rsp_valid, 1'b1);
        rd = rsp.rdata;
        hit = rsp.hit;
    endtask

    // Legal codes only, random bits elsewhere to exercise the masks
    function automatic logic [15:0] legal(input logic [15:0] a);
        case (a)
            DRC_ADDR_A_SLOPE_REL: return {8'($urandom), 2'($urandom_range(2)),
                3'($urandom_range(5)), 3'($urandom_range(4))};
            DRC_ADDR_A_KNEE: return {5'($urandom), 6'($urandom_range(60)),
                5'($urandom_range(30))};
            DRC_ADDR_B_TIMING: return {3'($urandom), 4'($urandom_range(11, 1)),
                4'($urandom_range(11)), 3'($urandom_range(4)), 2'($urandom)};
            default: return 16'($urandom);
        endcase
    endfunction

    // Applied settings as the register contents dictate
    function automatic logic [51:0] outs_exp();
        logic [15:0] sr, kn, gk, dt, tm;
        sr = regs[DRC_ADDR_A_SLOPE_REL];
        kn = regs[DRC_ADDR_A_KNEE];
        gk = regs[DRC_ADDR_A_GATE_KNEE];
        dt = regs[DRC_ADDR_B_DETECT];
        tm = regs[DRC_ADDR_B_TIMING];
        return {kn[10:0], sr[7:3], tm[12:2], dt[4], dt[3], sr[2:0],
            dt[8] ? gk[9:5] : 5'h00, dt[5] ? gk[4:0] : 5'h00,
            !dt[6] ? 10'h000 : dt[7] ? {5'h10, dt[15:11]} : {8'h00, dt[10:9]}};
    endfunction

    task wr_chk(input logic [15:0] a, input logic [15:0] wd);
        logic [15:0] rd;
        logic        hit;
        logic [51:0] ex;
        acc(1'b1, a, wd, rd, hit);
        regs[a] = wd & mk[a];
        @(posedge sys_clk) #1;
        ex = outs_exp();
        check({a_cfg, b_cfg}, ex[51:20]);
        check({gate_ap, thr}, ex[19:0]);
        acc(1'b0, a, 16'h0000, rd, hit);
        check({hit, rd}, {1'b1, regs[a]});
    endtask

    // Watchdog
    initial begin
        #20000;
        fails++;
        summarize();
    end

    initial begin
        logic [15:0] rd, wd;
        logic        hit, ex;
        logic [11:0] sx;
        void'($urandom(32'h15a06e2b));
        sx = 12'h000;
        repeat (4) @(posedge sys_clk);
        #1 rst = 1'b0;
        @(posedge sys_clk) #1;
        check({a_cfg, b_cfg, gate_ap, thr}, outs_exp());
        // Reset values, then one unmapped place
        foreach (adr[k]) begin
            acc(1'b0, adr[k], 16'h0000, rd, hit);
            check({hit, rd}, {1'b1, regs[adr[k]]});
        end
        acc(1'b0, 16'h0e85, 16'h0000, rd, hit);
        check({hit, rd}, 17'h00000);
        // Boundary codes, every gate and detect combination, then random
        wr_chk(DRC_ADDR_A_KNEE, {5'h00, 6'h3c, 5'h1e});
        wr_chk(DRC_ADDR_A_SLOPE_REL, {8'hff, 2'h2, 3'h5, 3'h4});
        wr_chk(DRC_ADDR_B_TIMING, {3'h7, 4'hb, 4'hb, 3'h4, 2'h3});
        wr_chk(DRC_ADDR_A_GATE_KNEE, 16'hffff);
        for (int i = 0; i < 16; i++) begin
            wd = legal(DRC_ADDR_B_DETECT);
            wd[8:5] = 4'(i);
            wr_chk(DRC_ADDR_B_DETECT, wd);
        end
        repeat (40) begin
            rd = adr[$urandom_range(4)];
            wr_chk(rd, legal(rd));
        end
        // Enable requests against a changing clock budget
        repeat (40) begin
            pen = 12'($urandom);
            fits = 12'($urandom | $urandom);
            ex = |(pen & ~sx & ~fits);
            sx = pen & (sx | fits);
            @(posedge sys_clk) #1;
            check(uerr, ex);
        end
        acc(1'b1, DRC_ADDR_FX_STATUS, 16'hffff, rd, hit);
        acc(1'b0, DRC_ADDR_FX_STATUS, 16'h0000, rd, hit);
        check({hit, rd}, {1'b1, sx, 4'h0});
        // Fill the buffer against a stalled sink, then drain
        src_on = 1'b1;
        stall = 1'b1;
        repeat (12) @(posedge sys_clk);
        #1;
        check({tx_n, in_ready, out_valid}, {32'd2, 1'b0, 1'b1});
        stall = 1'b0;
        repeat (300) @(posedge sys_clk);
        #1 src_on = 1'b0;
        repeat (60) @(posedge sys_clk);
        #1;
        check({rx_n, rx_bad, out_valid}, {tx_n, 32'd0, 1'b0});
        check(tx_n > 50, 1'b1);
        summarize();
    end
endmodule // tb
